// ==== pmid_bank.v ====
// identity bank: block read/write slave on the management bus pins
// assumes bus clock well below a quarter of i_core_clk; nvm image valid at reset
`timescale 1ns/10ps
`include "pmid_map.vh"
`default_nettype none

module pmid_bank #(
  parameter [6:0] BUS_ADDR = `PMID_BUS_ADDR_DEFAULT,
  parameter [47:0] IDENT_VALUE = `PMID_IDENT_DEFAULT
) (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_scl,
  input wire i_sda,
  output reg o_sda_out,
  output reg o_sda_oe_n,
  output reg o_alert_out,
  output reg o_alert_oe_n,
  input wire i_clear_faults,
  input wire [95:0] i_nvm_image,
  output reg [95:0] o_user_image,
  output reg [23:0] o_stored_image_checksum,
  output reg [7:0] o_comm_fault_register,
  output reg o_comm_fault_flag
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_ADDR = 3'd1;
  localparam [2:0] S_ACK = 3'd2;
  localparam [2:0] S_RX = 3'd3;
  localparam [2:0] S_TX = 3'd4;
  localparam [2:0] S_MACK = 3'd5;

  wire scl_level;
  wire scl_rise;
  wire scl_fall;
  wire sda_level;
  wire sda_rise;
  wire sda_fall;

  pmid_pin_sync u_scl_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(i_scl),
    .o_level(scl_level),
    .o_rise(scl_rise),
    .o_fall(scl_fall)
  );

  pmid_pin_sync u_sda_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(i_sda),
    .o_level(sda_level),
    .o_rise(sda_rise),
    .o_fall(sda_fall)
  );

  reg [2:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] tx_reg;
  reg is_read_reg;
  reg [3:0] byte_idx_reg;
  reg [7:0] cmd_reg;
  reg [7:0] count_reg;
  reg [3:0] data_cnt_reg;
  reg [23:0] wbuf_reg;
  reg [3:0] rd_idx_reg;
  reg [23:0] maker_id_store;
  reg [23:0] model_info_store;
  reg [23:0] revision_info_store;
  reg [23:0] serial_number_store;

  wire bus_start = sda_fall & scl_level;
  wire bus_stop = sda_rise & scl_level;
  wire [47:0] chip_identity_code = IDENT_VALUE;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire cmd_user = (cmd_reg == `PMID_CMD_MAKER_ID) | (cmd_reg == `PMID_CMD_MODEL_INFO) |
                  (cmd_reg == `PMID_CMD_REVISION_INFO) | (cmd_reg == `PMID_CMD_SERIAL_NUMBER);
  wire cmd_ident = (cmd_reg == `PMID_CMD_CHIP_IDENTITY);

  reg [23:0] user_sel;
  always @* begin
    case (cmd_reg)
      `PMID_CMD_MAKER_ID: user_sel = maker_id_store;
      `PMID_CMD_MODEL_INFO: user_sel = model_info_store;
      `PMID_CMD_REVISION_INFO: user_sel = revision_info_store;
      default: user_sel = serial_number_store;
    endcase
  end

  // byte count first, then payload low byte first
  reg [7:0] tx_next;
  always @* begin
    tx_next = `PMID_NO_DATA;
    if (cmd_ident) begin
      if (rd_idx_reg == 4'd0) begin
        tx_next = `PMID_IDENT_BYTES;
      end else if (rd_idx_reg <= 4'd6) begin
        tx_next = chip_identity_code[(rd_idx_reg - 4'd1) * 8 +: 8];
      end
    end else if (cmd_user) begin
      if (rd_idx_reg == 4'd0) begin
        tx_next = `PMID_USER_BYTES;
      end else if (rd_idx_reg <= 4'd3) begin
        tx_next = user_sel[(rd_idx_reg - 4'd1) * 8 +: 8];
      end
    end
  end

  // write to a read-only command, seen on the first byte after the command
  wire rx_done = scl_fall & (bit_cnt_reg == 4'd8);
  wire invalid_command_fault = rx_done & (state_reg == S_RX) & (byte_idx_reg == 4'd1) &
                               cmd_ident;
  // count or length mismatch only judged at stop, so a short write never lands
  wire write_seen = ~is_read_reg & cmd_user & (byte_idx_reg >= 4'd2);
  wire write_ok = (count_reg == `PMID_USER_BYTES) & (data_cnt_reg == 4'd3);
  wire commit = bus_stop & write_seen & write_ok;
  wire len_event = bus_stop & write_seen & ~write_ok;

  // ----------------------------------------------------------------
  // bus engine
  // ----------------------------------------------------------------
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      state_reg <= S_IDLE;
      bit_cnt_reg <= 4'd0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      is_read_reg <= 1'b0;
      byte_idx_reg <= 4'd0;
      cmd_reg <= 8'h00;
      count_reg <= 8'h00;
      data_cnt_reg <= 4'd0;
      wbuf_reg <= 24'h000000;
      rd_idx_reg <= 4'd0;
      o_sda_oe_n <= 1'b1;
    end else if (bus_stop) begin
      state_reg <= S_IDLE;
      o_sda_oe_n <= 1'b1;
    end else if (bus_start) begin
      // repeated start keeps the command byte for the read phase
      state_reg <= S_ADDR;
      bit_cnt_reg <= 4'd0;
      byte_idx_reg <= 4'd0;
      data_cnt_reg <= 4'd0;
      rd_idx_reg <= 4'd0;
      o_sda_oe_n <= 1'b1;
    end else begin
      if (scl_rise && (state_reg == S_ADDR || state_reg == S_RX)) begin
        shift_reg <= {shift_reg[6:0], sda_level};
        bit_cnt_reg <= bit_cnt_reg + 4'd1;
      end
      if (scl_rise && state_reg == S_MACK && sda_level) begin
        state_reg <= S_IDLE;
      end
      if (scl_fall) begin
        case (state_reg)
          S_ADDR: begin
            if (bit_cnt_reg == 4'd8 && shift_reg[7:1] == BUS_ADDR) begin
              is_read_reg <= shift_reg[0];
              o_sda_oe_n <= 1'b0;
              state_reg <= S_ACK;
            end else if (bit_cnt_reg == 4'd8) begin
              state_reg <= S_IDLE;
            end
          end
          S_RX: begin
            if (bit_cnt_reg == 4'd8) begin
              if (byte_idx_reg == 4'd0) begin
                cmd_reg <= shift_reg;
              end else if (byte_idx_reg == 4'd1) begin
                count_reg <= shift_reg;
              end else if (data_cnt_reg < 4'd3) begin
                wbuf_reg[data_cnt_reg[1:0] * 8 +: 8] <= shift_reg;
                data_cnt_reg <= data_cnt_reg + 4'd1;
              end else begin
                data_cnt_reg <= 4'd4;
              end
              if (byte_idx_reg != 4'hF) begin
                byte_idx_reg <= byte_idx_reg + 4'd1;
              end
              o_sda_oe_n <= 1'b0;
              state_reg <= S_ACK;
            end
          end
          S_ACK: begin
            bit_cnt_reg <= 4'd0;
            if (is_read_reg) begin
              tx_reg <= {tx_next[6:0], 1'b0};
              o_sda_oe_n <= tx_next[7];
              rd_idx_reg <= rd_idx_reg + 4'd1;
              state_reg <= S_TX;
            end else begin
              o_sda_oe_n <= 1'b1;
              state_reg <= S_RX;
            end
          end
          S_TX: begin
            if (bit_cnt_reg == 4'd7) begin
              o_sda_oe_n <= 1'b1;
              state_reg <= S_MACK;
            end else begin
              o_sda_oe_n <= tx_reg[7];
              tx_reg <= {tx_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 4'd1;
            end
          end
          S_MACK: begin
            bit_cnt_reg <= 4'd0;
            tx_reg <= {tx_next[6:0], 1'b0};
            o_sda_oe_n <= tx_next[7];
            if (rd_idx_reg != 4'hF) begin
              rd_idx_reg <= rd_idx_reg + 4'd1;
            end
            state_reg <= S_TX;
          end
          default: state_reg <= S_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // user fields, reset from the stored image
  // ----------------------------------------------------------------
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      maker_id_store <= i_nvm_image[`PMID_IMG_MAKER_LSB +: 24];
      model_info_store <= i_nvm_image[`PMID_IMG_MODEL_LSB +: 24];
      revision_info_store <= i_nvm_image[`PMID_IMG_REV_LSB +: 24];
      serial_number_store <= i_nvm_image[`PMID_IMG_SERIAL_LSB +: 24];
    end else if (commit) begin
      case (cmd_reg)
        `PMID_CMD_MAKER_ID: maker_id_store <= wbuf_reg;
        `PMID_CMD_MODEL_INFO: model_info_store <= wbuf_reg;
        `PMID_CMD_REVISION_INFO: revision_info_store <= wbuf_reg;
        default: serial_number_store <= wbuf_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // image out, checksum and faults
  // ----------------------------------------------------------------
  // xor fold keeps the sum one-to-one in the serial for fixed other fields
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_user_image <= 96'h0;
      o_stored_image_checksum <= 24'h000000;
      o_comm_fault_register <= `PMID_CF_RESET;
      o_comm_fault_flag <= 1'b0;
      o_alert_oe_n <= 1'b1;
      o_alert_out <= 1'b0;
      o_sda_out <= 1'b0;
    end else begin
      o_user_image <= {serial_number_store, revision_info_store, model_info_store,
                       maker_id_store};
      o_stored_image_checksum <= maker_id_store ^ model_info_store ^ revision_info_store ^
                                 serial_number_store;
      // set wins over a clear in the same cycle
      o_comm_fault_register[`PMID_CF_INVALID_CMD_BIT] <= invalid_command_fault |
        (o_comm_fault_register[`PMID_CF_INVALID_CMD_BIT] & ~i_clear_faults);
      o_comm_fault_register[`PMID_CF_OTHER_BIT] <= len_event |
        (o_comm_fault_register[`PMID_CF_OTHER_BIT] & ~i_clear_faults);
      o_comm_fault_flag <= invalid_command_fault | len_event |
        (o_comm_fault_flag & ~i_clear_faults);
      o_alert_oe_n <= ~(invalid_command_fault | len_event |
        (o_comm_fault_flag & ~i_clear_faults));
    end
  end

endmodule // pmid_bank

`default_nettype wire

// ==== pmid_bank_props.sv ====
// assertions on the identity bank ports
// assumes it is bound into pmid_bank
`timescale 1ns/10ps
`default_nettype none
module pmid_bank_props (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe_n,
  input wire logic o_alert_out,
  input wire logic o_alert_oe_n,
  input wire logic i_clear_faults,
  input wire logic [95:0] i_nvm_image,
  input wire logic [95:0] o_user_image,
  input wire logic [23:0] o_stored_image_checksum,
  input wire logic [7:0] o_comm_fault_register,
  input wire logic o_comm_fault_flag
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  // -------------------------------
  // properties
  // -------------------------------
  AST_CSUM_XOR: assert property (o_stored_image_checksum == (o_user_image[23:0]
    ^ o_user_image[47:24] ^ o_user_image[71:48] ^ o_user_image[95:72]))
    else $error("checksum does not match user image");
  AST_NVM_LOAD: assert property ($fell(i_rst) |-> ##[1:3] o_user_image == i_nvm_image)
    else $error("fields not loaded from stored copy");
  AST_BADCMD_SUMMARY: assert property ($rose(o_comm_fault_register[7]) |-> o_comm_fault_flag)
    else $error("summary flag missing on invalid command");
  AST_BADCMD_STICKY: assert property (o_comm_fault_register[7] && !i_clear_faults |=>
    o_comm_fault_register[7]) else $error("invalid command bit lost");
  AST_ALERT_LEVEL: assert property (o_alert_oe_n == !o_comm_fault_flag)
    else $error("alert does not follow fault flag");
  AST_FLAG_CAUSE: assert property (o_comm_fault_flag |-> o_comm_fault_register != 8'h00)
    else $error("summary flag without fault bit");
  AST_CLEAR: assert property (i_clear_faults [*2] |-> !o_comm_fault_flag &&
    o_comm_fault_register == 8'h00) else $error("faults not cleared");
  AST_UNUSED_BITS: assert property (o_comm_fault_register[6:2] == 5'h00 &&
    !o_comm_fault_register[0]) else $error("unused fault bit set");
  AST_DRIVE_LOW: assert property (!o_sda_out && !o_alert_out)
    else $error("open drain pin driven high");
  cover property ($fell(i_sda) && i_scl);
  cover property ($fell(o_sda_oe_n));
  cover property ($rose(o_comm_fault_register[7]));
  cover property ($rose(o_comm_fault_register[1]));
endmodule // pmid_bank_props
bind pmid_bank pmid_bank_props chk_u (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_scl(i_scl),
  .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n), .o_alert_out(o_alert_out),
  .o_alert_oe_n(o_alert_oe_n), .i_clear_faults(i_clear_faults), .i_nvm_image(i_nvm_image),
  .o_user_image(o_user_image), .o_stored_image_checksum(o_stored_image_checksum),
  .o_comm_fault_register(o_comm_fault_register), .o_comm_fault_flag(o_comm_fault_flag));
`default_nettype wire

// ==== pmid_host_model.sv ====
// host side of the management bus: makes scl, drives sda open-drain
// assumes the bench forms the sda line from all enables, pulled high
`timescale 1ns/10ps
`default_nettype none
module pmid_host_model #(
  parameter logic [6:0] ADDR = 7'h3A
) (
  input wire logic i_core_clk,
  input wire logic i_sda_line,
  output var logic o_scl,
  output var logic o_sda_rel
);
  // scl stands high outside frames
  initial begin
    o_scl = 1'b1;
    o_sda_rel = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  // -------------------------------
  // bit, byte and framing
  // -------------------------------
  // 4 low plus 4 high core clocks: 400 ns per bit
  task automatic bit_io(input logic b, output logic r);
    o_scl <= 1'b0;
    wt(2);
    o_sda_rel <= b;
    wt(2);
    o_scl <= 1'b1;
    wt(2);
    r = i_sda_line;
    wt(2);
  endtask
  task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) bit_io(tx[i], rx[i]);
  endtask
  // serves as start and as repeated start
  task automatic start;
    o_scl <= 1'b0;
    wt(4);
    o_sda_rel <= 1'b1;
    wt(2);
    o_scl <= 1'b1;
    wt(4);
    o_sda_rel <= 1'b0;
    wt(4);
  endtask
  task automatic stop;
    o_scl <= 1'b0;
    wt(2);
    o_sda_rel <= 1'b0;
    wt(2);
    o_scl <= 1'b1;
    wt(4);
    o_sda_rel <= 1'b1;
    wt(8);
  endtask
  // -------------------------------
  // block transfers, low byte first
  // -------------------------------
  task automatic wr_blk(input logic [7:0] cmd, input logic [7:0] cnt, input int n,
                        input logic [47:0] d, output logic nak);
    logic [8:0] r;
    start();
    byte_io({ADDR, 2'b01}, r);
    nak = r[0];
    byte_io({cmd, 1'b1}, r);
    nak |= r[0];
    byte_io({cnt, 1'b1}, r);
    nak |= r[0];
    for (int i = 0; i < n; i++) begin
      byte_io({d[8*i +: 8], 1'b1}, r);
      nak |= r[0];
    end
    stop();
  endtask
  task automatic rd_blk(input logic [7:0] cmd, input int n, output logic [7:0] cnt,
                        output logic [47:0] d);
    logic [8:0] r;
    d = '0;
    start();
    byte_io({ADDR, 2'b01}, r);
    byte_io({cmd, 1'b1}, r);
    start();
    byte_io({ADDR, 2'b11}, r);
    byte_io(9'h1FE, r);
    cnt = r[8:1];
    for (int i = 0; i < n; i++) begin
      // nack on the last byte ends the read
      byte_io({8'hFF, i == n - 1}, r);
      d[8*i +: 8] = r[8:1];
    end
    stop();
  endtask
endmodule // pmid_host_model
`default_nettype wire

// ==== pmid_map.vh ====
// constants for the identity bank: command codes, field layout, fault bits
// assumes inclusion by every identity bank source file that uses these macros
`ifndef PMID_MAP_VH
`define PMID_MAP_VH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define PMID_CMD_MAKER_ID 8'h99
`define PMID_CMD_MODEL_INFO 8'h9A
`define PMID_CMD_REVISION_INFO 8'h9B
`define PMID_CMD_SERIAL_NUMBER 8'h9E
`define PMID_CMD_CHIP_IDENTITY 8'hAD

// ----------------------------------------------------------------
// payload sizes and field layout
// ----------------------------------------------------------------
`define PMID_USER_BYTES 8'h03
`define PMID_IDENT_BYTES 8'h06
`define PMID_FIELD_W 24
`define PMID_IDENT_W 48
`define PMID_IMAGE_W 96
`define PMID_IMG_MAKER_LSB 0
`define PMID_IMG_MODEL_LSB 24
`define PMID_IMG_REV_LSB 48
`define PMID_IMG_SERIAL_LSB 72

// ----------------------------------------------------------------
// fault bits and defaults
// ----------------------------------------------------------------
`define PMID_CF_INVALID_CMD_BIT 7
`define PMID_CF_OTHER_BIT 1
`define PMID_CF_RESET 8'h00
// arbitrary default bus address
`define PMID_BUS_ADDR_DEFAULT 7'h3A
// arbitrary identity value, not any real part code
`define PMID_IDENT_DEFAULT 48'hA5A5_0102_0304
`define PMID_NO_DATA 8'hFF

`endif

// ==== pmid_pin_sync.v ====
// two-flop synchroniser with edge detection for one bus pin
// assumes the pin is asynchronous to i_core_clk and idles high
`timescale 1ns/10ps
`default_nettype none

module pmid_pin_sync (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_pin,
  output wire o_level,
  output wire o_rise,
  output wire o_fall
);

  reg meta_reg;
  reg sync_reg;
  reg last_reg;

  // meta_reg is read only by sync_reg
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end else begin
      meta_reg <= i_pin;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign o_level = sync_reg;
  assign o_rise = sync_reg & ~last_reg;
  assign o_fall = ~sync_reg & last_reg;

endmodule // pmid_pin_sync

`default_nettype wire

// ==== test_pmid_bank.sv ====
// self-checking bench for the identity bank
// assumes the host model and the bound checker are compiled with it
`timescale 1ns/10ps
`include "pmid_map.vh"
`default_nettype none
module test_pmid_bank;
  localparam logic [95:0] NVM = 96'h1E2D3C_4B5A69_788796_A5B4C3;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clr = 1'b0;
  logic [95:0] nvm = NVM;
  logic [95:0] exp_img;
  logic [31:0] rows [4];
  logic [7:0] cnt;
  logic [47:0] rd;
  logic nak;
  int errors = 0;
  int comparisons = 0;
  wire logic scl, sda_rel, sda_oe_n, alert_oe_n, flag;
  wire logic [95:0] img;
  wire logic [23:0] csum;
  wire logic [7:0] cfr;
  // released line is pulled high
  wire logic sda_line = sda_rel & sda_oe_n;
  always #25 clk = ~clk;
  pmid_bank dut_u (.i_core_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda_line),
    .o_sda_out(), .o_sda_oe_n(sda_oe_n), .o_alert_out(), .o_alert_oe_n(alert_oe_n),
    .i_clear_faults(clr), .i_nvm_image(nvm), .o_user_image(img),
    .o_stored_image_checksum(csum), .o_comm_fault_register(cfr), .o_comm_fault_flag(flag));
  pmid_host_model #(.ADDR(`PMID_BUS_ADDR_DEFAULT)) host_u (.i_core_clk(clk),
    .i_sda_line(sda_line), .o_scl(scl), .o_sda_rel(sda_rel));
  task automatic chk(input string what, input logic [95:0] exp, input logic [95:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out;
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic clear_faults;
    clr <= 1'b1;
    repeat (2) @(posedge clk);
    clr <= 1'b0;
    @(posedge clk);
    chk("faults after clear", 96'h1, {cfr, flag, alert_oe_n});
  endtask
  task automatic restart;
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  initial begin
    rows[0] = {`PMID_CMD_MAKER_ID, 24'h112233};
    rows[1] = {`PMID_CMD_MODEL_INFO, 24'hA0B1C2};
    rows[2] = {`PMID_CMD_REVISION_INFO, 24'h000001};
    rows[3] = {`PMID_CMD_SERIAL_NUMBER, 24'hFFFFFE};
    exp_img = NVM;
    restart();
    chk("faults after reset", 96'h1, {cfr, flag, alert_oe_n});
    chk("image after reset", exp_img, img);
    host_u.rd_blk(`PMID_CMD_MAKER_ID, 3, cnt, rd);
    chk("maker id after reset", NVM[23:0], rd);
    foreach (rows[i]) begin
      host_u.wr_blk(rows[i][31:24], `PMID_USER_BYTES, 3, {24'h0, rows[i][23:0]}, nak);
      chk("write ack", 96'h0, nak);
      host_u.rd_blk(rows[i][31:24], 3, cnt, rd);
      chk("read count", 96'h3, cnt);
      chk("read value", rows[i][23:0], rd);
      exp_img[24*i +: 24] = rows[i][23:0];
      chk("user image", exp_img, img);
      chk("checksum", exp_img[23:0] ^ exp_img[47:24] ^ exp_img[71:48] ^ exp_img[95:72],
        csum);
    end
    // short count must leave the serial untouched
    host_u.wr_blk(`PMID_CMD_SERIAL_NUMBER, 8'h02, 2, 48'h5A5A, nak);
    chk("short count faults", 96'hA, {cfr, flag, alert_oe_n});
    clear_faults();
    // an extra data byte is a count error as well
    host_u.wr_blk(`PMID_CMD_SERIAL_NUMBER, `PMID_USER_BYTES, 4, 48'h0D0C0B0A, nak);
    chk("long write faults", 96'hA, {cfr, flag, alert_oe_n});
    clear_faults();
    host_u.wr_blk(`PMID_CMD_CHIP_IDENTITY, 8'h03, 3, 48'h0C0B0A, nak);
    chk("read-only faults", 96'h202, {cfr, flag, alert_oe_n});
    host_u.rd_blk(`PMID_CMD_CHIP_IDENTITY, 6, cnt, rd);
    chk("identity count", 96'h6, cnt);
    chk("identity value", `PMID_IDENT_DEFAULT, rd);
    host_u.rd_blk(`PMID_CMD_SERIAL_NUMBER, 3, cnt, rd);
    chk("serial kept", rows[3][23:0], rd);
    clear_faults();
    // new stored copy proves the fields reload from it at reset
    nvm <= ~NVM;
    restart();
    chk("image after reload", ~NVM, img);
    close_out();
  end
  // whole run is near 7350 clocks
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    close_out();
  end
endmodule // test_pmid_bank
`default_nettype wire
